// ---- core/mmt_defs.svh ----
// constants of the multi-mode timer/capture block
`ifndef MMT_DEFS_SVH
`define MMT_DEFS_SVH

`define MMT_CNT_W        16
`define MMT_PRE_W        24
`define MMT_SHIFT_W      5
`define MMT_DIV_BASE     3
`define MMT_DIV_STEP     2
`define MMT_FC_REJECT    7
`define MMT_FC_DETECT    24
`define MMT_FLT_W        5
`define MMT_CNT_RST      16'h0000
`define MMT_CMP_RST      16'hFFFF
`define MMT_CAP_RST      16'h0000
`define MMT_START_STOP   2'h0
`define MMT_START_CMD    2'h1
`define MMT_START_EXT    2'h3
`define MMT_MODE_TIMER   3'h0
`define MMT_MODE_EXTTRIG 3'h1
`define MMT_MODE_EVENT   3'h2
`define MMT_MODE_WINDOW  3'h3
`define MMT_MODE_PULSE   3'h4
`define MMT_CAPM_DOUBLE  1'h0
`define MMT_CAPM_SINGLE  1'h1

`endif

// ---- core/mmt_pkg.sv ----
// types of the multi-mode timer/capture block
package mmt_pkg;
   typedef enum logic [1:0] {
      MMT_ST_STOP,
      MMT_ST_WAIT,
      MMT_ST_RUN
   } mmt_state_e;
   typedef logic [15:0] mmt_count_t;
endpackage

// ---- core/mmt_edge_if.sv ----
// carrier between the pin noise filter and the timer core
`timescale 1ns/100ps
interface mmt_edge_if;
   logic raw;
   logic level;
   logic rise;
   logic fall;
   modport filt (input raw, output level, output rise, output fall);
   modport user (output raw, input level, input rise, input fall);
endinterface

// ---- core/mmt_edge_filter.sv ----
// noise rejection and edge detection on the event input pin
`timescale 1ns/100ps
`include "mmt_defs.svh"
module mmt_edge_filter
   import mmt_pkg::*;
(
   input  logic  sys_clk_in,
   input  logic  srst_in,
   mmt_edge_if.filt edge_port
);
   logic [`MMT_FLT_W-1:0] stable_cnt;
   logic                  level;

   // a change must persist past the reject window before it is taken
   always_ff @(posedge sys_clk_in) begin
      if (srst_in) begin
         stable_cnt <= '0;
      end else if (edge_port.raw == level) begin
         stable_cnt <= '0;
      end else if (stable_cnt == `MMT_FLT_W'(`MMT_FC_REJECT)) begin
         stable_cnt <= '0;
      end else begin
         stable_cnt <= stable_cnt + `MMT_FLT_W'(1);
      end
   end

   always_ff @(posedge sys_clk_in) begin
      if (srst_in) begin
         level <= 1'b0;
      end else if (edge_port.raw != level &&
                   stable_cnt == `MMT_FLT_W'(`MMT_FC_REJECT)) begin
         level <= edge_port.raw;
      end
   end

   always_ff @(posedge sys_clk_in) begin
      if (srst_in) begin
         edge_port.rise <= 1'b0;
         edge_port.fall <= 1'b0;
      end else begin
         edge_port.rise <= ~level & edge_port.raw &
                           (stable_cnt == `MMT_FLT_W'(`MMT_FC_REJECT));
         edge_port.fall <= level & ~edge_port.raw &
                           (stable_cnt == `MMT_FLT_W'(`MMT_FC_REJECT));
      end
   end

   assign edge_port.level = level;
endmodule

// ---- core/mmt_timer.sv ----
// 16-bit multi-mode timer/counter with compare and capture
// Behaviour
// - timer mode: count internal clock, on compare match interrupt, clear, keep counting
// - soft capture bit copies counter to capture register except in pulse mode, then clears itself
// - external trigger mode starts counting internal clock at selected pin edge
// - external trigger mode: match interrupts, clears, halts until next selected edge
// - pin pulses of 7 clocks or less rejected; source holds 24 clocks
// - event mode counts selected pin edges; match interrupts and clears counter
// - window mode counts rising edges of window AND internal clock; match clears
// - edge polarity bit picks active-high or active-low window
// - pulse mode with external start begins counting at the selected edge
// - pulse mode: opposite edge captures counter and raises the interrupt
// - single edge capture clears counter at the capture edge
// - double edge capture keeps counting, captures again at next start edge
// - capture edge mode bit selects single/double; polarity from edge select
// - start control: 00 stop and clear, 01 command, 11 trigger, 10 reserved
// - capture edge mode 0 means double edge, 1 means single edge
// - trigger stop select 1 lets a trigger edge also stop the counter
`timescale 1ns/100ps
`include "mmt_defs.svh"
module mmt_timer
   import mmt_pkg::*;
(
   input  logic       sys_clk_in,
   input  logic       srst_in,
   input  logic       event_input_pin_in,
   input  logic [2:0] mode_in,
   input  logic [2:0] source_clock_select_in,
   input  logic [1:0] start_control_in,
   input  logic       edge_polarity_select_in,
   input  logic       capture_edge_mode_in,
   input  logic       trigger_stop_select_in,
   input  logic       soft_capture_set_in,
   input  logic       cmp_wr_lo_in,
   input  logic       cmp_wr_hi_in,
   input  logic [7:0] cmp_wdata_in,
   output logic [15:0] counter_out,
   output logic [7:0] capture_lo_out,
   output logic [7:0] capture_hi_out,
   output logic       timer_match_irq_out,
   output logic       soft_capture_trigger_out,
   output logic       running_out,
   output logic       waiting_out,
   output logic       compare_armed_out
);
   mmt_edge_if edge_bus ();

   mmt_state_e            state;
   mmt_count_t            counter;
   mmt_count_t            compare_reg_a;
   mmt_count_t            capture_reg_b;
   logic [`MMT_PRE_W-1:0] prescaler;
   logic [`MMT_SHIFT_W-1:0] clk_shift;
   logic                  int_lvl;
   logic                  int_lvl_d;
   logic                  gate_lvl;
   logic                  gate_lvl_d;
   logic                  int_tick;
   logic                  win_tick;
   logic                  start_edge;
   logic                  stop_edge;
   logic                  win_active;
   logic                  cnt_tick;
   logic                  match;
   logic                  cmp_inhibit;
   logic                  soft_capture_trigger;
   logic                  soft_cap_do;
   logic                  pw_mode;
   logic                  pw_phase;
   logic                  pw_cap;
   logic                  pw_cap_2nd;
   logic                  trig_stop;
   logic                  irq;
   mmt_count_t            next_count;

   assign edge_bus.raw = event_input_pin_in;

   mmt_edge_filter u_filter (
      .sys_clk_in (sys_clk_in),
      .srst_in    (srst_in),
      .edge_port  (edge_bus.filt)
   );

   // free-running divider; each selectable rate is one tap of it
   always_ff @(posedge sys_clk_in) begin
      if (srst_in) begin
         prescaler <= '0;
      end else begin
         prescaler <= prescaler + `MMT_PRE_W'(1);
      end
   end

   assign clk_shift = `MMT_SHIFT_W'(`MMT_DIV_BASE +
                      32'(source_clock_select_in) * `MMT_DIV_STEP);
   assign int_lvl   = prescaler[clk_shift];

   // selected polarity: 0 rising / active high, 1 falling / active low
   assign start_edge = edge_polarity_select_in ? edge_bus.fall : edge_bus.rise;
   assign stop_edge  = edge_polarity_select_in ? edge_bus.rise : edge_bus.fall;
   assign win_active = edge_bus.level ^ edge_polarity_select_in;
   assign gate_lvl   = win_active & int_lvl;

   always_ff @(posedge sys_clk_in) begin
      if (srst_in) begin
         int_lvl_d  <= 1'b0;
         gate_lvl_d <= 1'b0;
      end else begin
         int_lvl_d  <= int_lvl;
         gate_lvl_d <= gate_lvl;
      end
   end

   assign int_tick = int_lvl & ~int_lvl_d;
   assign win_tick = gate_lvl & ~gate_lvl_d;

   always_comb begin
      case (mode_in)
         `MMT_MODE_EVENT:  cnt_tick = start_edge;
         `MMT_MODE_WINDOW: cnt_tick = win_tick;
         default:          cnt_tick = int_tick;
      endcase
   end

   assign pw_mode    = (mode_in == `MMT_MODE_PULSE);
   assign next_count = counter + 16'h0001;
   // a half-written compare value never matches
   assign match      = (state == MMT_ST_RUN) && cnt_tick && !pw_mode &&
                       !cmp_inhibit && (next_count == compare_reg_a);
   // opposite edge first, then (double mode) the start-polarity edge
   assign pw_cap     = pw_mode && (state == MMT_ST_RUN) &&
                       (pw_phase ? start_edge : stop_edge);
   assign pw_cap_2nd = pw_cap && pw_phase;
   assign trig_stop  = (mode_in == `MMT_MODE_EXTTRIG) && trigger_stop_select_in &&
                       (state == MMT_ST_RUN) && start_edge;
   assign soft_cap_do = soft_capture_trigger && !pw_mode;

   // run control
   always_ff @(posedge sys_clk_in) begin
      if (srst_in) begin
         state <= MMT_ST_STOP;
      end else if (start_control_in == `MMT_START_STOP) begin
         state <= MMT_ST_STOP;
      end else begin
         case (state)
            MMT_ST_STOP: begin
               if (start_control_in == `MMT_START_CMD) begin
                  state <= MMT_ST_RUN;
               end else if (start_control_in == `MMT_START_EXT) begin
                  state <= MMT_ST_WAIT;
               end
            end
            MMT_ST_WAIT: begin
               if (start_edge) begin
                  state <= MMT_ST_RUN;
               end
            end
            MMT_ST_RUN: begin
               if (match && mode_in == `MMT_MODE_EXTTRIG) begin
                  state <= MMT_ST_WAIT;
               end else if (trig_stop) begin
                  state <= MMT_ST_WAIT;
               end else if (pw_cap && !pw_phase &&
                            capture_edge_mode_in == `MMT_CAPM_SINGLE &&
                            start_control_in == `MMT_START_EXT) begin
                  state <= MMT_ST_WAIT;
               end
            end
            default: state <= MMT_ST_STOP;
         endcase
      end
   end

   // pulse measurement phase: 0 waits opposite edge, 1 waits start edge
   always_ff @(posedge sys_clk_in) begin
      if (srst_in) begin
         pw_phase <= 1'b0;
      end else if (state != MMT_ST_RUN || !pw_mode) begin
         pw_phase <= 1'b0;
      end else if (pw_cap) begin
         pw_phase <= !pw_phase && (capture_edge_mode_in == `MMT_CAPM_DOUBLE);
      end
   end

   // the up-counter
   always_ff @(posedge sys_clk_in) begin
      if (srst_in) begin
         counter <= `MMT_CNT_RST;
      end else if (start_control_in == `MMT_START_STOP) begin
         counter <= `MMT_CNT_RST;
      end else if (state == MMT_ST_RUN) begin
         if (pw_cap && (pw_cap_2nd ||
                        capture_edge_mode_in == `MMT_CAPM_SINGLE)) begin
            counter <= `MMT_CNT_RST;
         end else if (match) begin
            counter <= `MMT_CNT_RST;
         end else if (trig_stop) begin
            counter <= counter;
         end else if (cnt_tick) begin
            counter <= next_count;
         end
      end
   end

   // compare register, written a byte at a time
   always_ff @(posedge sys_clk_in) begin
      if (srst_in) begin
         compare_reg_a <= `MMT_CMP_RST;
      end else if (cmp_wr_hi_in) begin
         compare_reg_a[15:8] <= cmp_wdata_in;
      end else if (cmp_wr_lo_in) begin
         compare_reg_a[7:0] <= cmp_wdata_in;
      end
   end

   always_ff @(posedge sys_clk_in) begin
      if (srst_in) begin
         cmp_inhibit <= 1'b0;
      end else if (cmp_wr_hi_in) begin
         cmp_inhibit <= 1'b0;
      end else if (cmp_wr_lo_in) begin
         cmp_inhibit <= 1'b1;
      end
   end

   // software capture request; a new request beats the self-clear
   always_ff @(posedge sys_clk_in) begin
      if (srst_in) begin
         soft_capture_trigger <= 1'b0;
      end else if (soft_capture_set_in) begin
         soft_capture_trigger <= 1'b1;
      end else if (soft_capture_trigger) begin
         soft_capture_trigger <= 1'b0;
      end
   end

   // capture register; an edge capture wins over a software capture
   always_ff @(posedge sys_clk_in) begin
      if (srst_in) begin
         capture_reg_b <= `MMT_CAP_RST;
      end else if (pw_cap) begin
         capture_reg_b <= counter;
      end else if (soft_cap_do) begin
         capture_reg_b <= counter;
      end
   end

   always_ff @(posedge sys_clk_in) begin
      if (srst_in) begin
         irq <= 1'b0;
      end else begin
         irq <= match || pw_cap;
      end
   end

   assign counter_out              = counter;
   assign capture_lo_out           = capture_reg_b[7:0];
   assign capture_hi_out           = capture_reg_b[15:8];
   assign timer_match_irq_out      = irq;
   assign soft_capture_trigger_out = soft_capture_trigger;
   assign running_out              = (state == MMT_ST_RUN);
   assign waiting_out              = (state == MMT_ST_WAIT);
   assign compare_armed_out        = !cmp_inhibit;
endmodule

// ---- tb/mmt_timer_asserts.sv ----
// concurrent checks on the ports of the multi-mode timer/capture block
`timescale 1ns/100ps
`include "mmt_defs.svh"
module mmt_timer_asserts (
   input wire logic        sys_clk_in,
   input wire logic        srst_in,
   input wire logic [2:0]  mode_in,
   input wire logic [1:0]  start_control_in,
   input wire logic        soft_capture_set_in,
   input wire logic        cmp_wr_lo_in,
   input wire logic        cmp_wr_hi_in,
   input wire logic [15:0] counter_out,
   input wire logic [7:0]  capture_lo_out,
   input wire logic [7:0]  capture_hi_out,
   input wire logic        timer_match_irq_out,
   input wire logic        soft_capture_trigger_out,
   input wire logic        running_out,
   input wire logic        waiting_out,
   input wire logic        compare_armed_out
);
   default clocking dc @(posedge sys_clk_in);
   endclocking
   default disable iff (srst_in);
   property p_stop;
      start_control_in == `MMT_START_STOP |=> counter_out == 16'h0000 && !running_out;
   endproperty
   a_stop: assert property (p_stop)
      else $error("stop did not clear counter");
   property p_cmd;
      start_control_in == `MMT_START_CMD && $past(start_control_in) == 2'h0 |=> running_out;
   endproperty
   a_cmd: assert property (p_cmd)
      else $error("command start not running");
   property p_ext;
      start_control_in == `MMT_START_EXT && $past(start_control_in) == 2'h0 |=> waiting_out;
   endproperty
   a_ext: assert property (p_ext)
      else $error("trigger start not waiting");
   property p_rsv;
      start_control_in == 2'h2 && $past(start_control_in) == 2'h0 |=> !running_out && !waiting_out;
   endproperty
   a_rsv: assert property (p_rsv)
      else $error("reserved start code started");
   property p_soft;
      soft_capture_set_in ##1 !soft_capture_set_in |->
         soft_capture_trigger_out ##1 !soft_capture_trigger_out;
   endproperty
   a_soft: assert property (p_soft)
      else $error("soft capture bit did not self clear");
   // the copy takes the count held before the capturing edge
   property p_cap;
      soft_capture_trigger_out && mode_in != `MMT_MODE_PULSE |=>
         {capture_hi_out, capture_lo_out} == $past(counter_out);
   endproperty
   a_cap: assert property (p_cap)
      else $error("soft capture value wrong");
   property p_cnt;
      $changed(counter_out) && counter_out != 16'h0000 |-> counter_out == $past(counter_out) + 16'h1;
   endproperty
   a_cnt: assert property (p_cnt)
      else $error("counter skipped a value");
   property p_irq;
      timer_match_irq_out && mode_in != `MMT_MODE_PULSE |->
         counter_out == 16'h0000 ##1 !timer_match_irq_out;
   endproperty
   a_irq: assert property (p_irq)
      else $error("match without clear or long pulse");
   property p_halt;
      timer_match_irq_out && mode_in == `MMT_MODE_EXTTRIG |-> waiting_out && !running_out;
   endproperty
   a_halt: assert property (p_halt)
      else $error("trigger timer not halted on match");
   // a half-written compare value must not be able to match
   property p_arm;
      cmp_wr_lo_in && !cmp_wr_hi_in |=> !compare_armed_out;
   endproperty
   a_arm: assert property (p_arm)
      else $error("low byte write left matching armed");
   property p_rearm;
      cmp_wr_hi_in |=> compare_armed_out;
   endproperty
   a_rearm: assert property (p_rearm)
      else $error("high byte write did not rearm matching");
endmodule
bind mmt_timer mmt_timer_asserts i_mmt_timer_asserts (.*);

// ---- tb/mmt_pin_src.sv ----
// external event source driving the timer's input pin
`timescale 1ns/100ps
module mmt_pin_src (
   input  wire logic sys_clk_in,
   output logic      pin_out
);
   localparam int MIN_HOLD = 24;
   initial pin_out = 1'b0;
   // never shorter than the detect width, so edges are also slower than clock/16
   task automatic hold(input logic v, input int n);
      pin_out <= v;
      repeat ((n < MIN_HOLD) ? MIN_HOLD : n) @(posedge sys_clk_in);
   endtask
   task automatic pulse(input int h, input int l);
      hold(1'b1, h);
      hold(1'b0, l);
   endtask
   // deliberate spike that must be dropped as noise
   task automatic spike(input int n);
      pin_out <= 1'b1;
      repeat (n) @(posedge sys_clk_in);
      hold(1'b0, MIN_HOLD);
   endtask
endmodule

// ---- tb/mmt_timer_tb.sv ----
// self-checking bench of the multi-mode timer/capture block
`timescale 1ns/100ps
`include "mmt_defs.svh"
module mmt_timer_tb;
   logic        sys_clk_in = 1'b0;
   logic        srst_in = 1'b1;
   logic        event_input_pin_in;
   logic [2:0]  mode_in = 3'h0;
   logic [2:0]  source_clock_select_in = 3'h0;
   logic [1:0]  start_control_in = 2'h0;
   logic        edge_polarity_select_in = 1'b0;
   logic        capture_edge_mode_in = 1'b1;
   logic        trigger_stop_select_in = 1'b0;
   logic        soft_capture_set_in = 1'b0;
   logic        cmp_wr_lo_in = 1'b0;
   logic        cmp_wr_hi_in = 1'b0;
   logic [7:0]  cmp_wdata_in = 8'h00;
   logic [15:0] counter_out;
   logic [7:0]  capture_lo_out;
   logic [7:0]  capture_hi_out;
   logic        timer_match_irq_out;
   logic        soft_capture_trigger_out;
   logic        running_out;
   logic        waiting_out;
   logic        compare_armed_out;
   int          fail_count = 0;
   int          comparisons = 0;
   int          seed = 48380;
   int          ticks = 0;
   int          t0;
   int          t1;
   int          sel = 0;
   logic        cem = 1'b1;
   logic        tss = 1'b0;
   logic [15:0] c;
   logic [15:0] obs;
   logic [16:0] nt;
   logic [16:0] notes[$];
   mmt_timer i_mmt_timer (.*);
   mmt_pin_src i_mmt_pin_src (.sys_clk_in, .pin_out(event_input_pin_in));
   always #2 sys_clk_in = ~sys_clk_in;
   always @(posedge sys_clk_in) ticks <= ticks + 1;
   task automatic check(input logic [19:0] seen, input logic [19:0] exp);
      comparisons++;
      if (seen !== exp) begin
         fail_count++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic tally_and_finish;
      $display("comparisons=%0d fail_count=%0d", comparisons, fail_count);
      if (fail_count == 0 && comparisons > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge sys_clk_in);
   endtask
   task automatic look(input int n);
      repeat (n) @(posedge sys_clk_in);
      @(negedge sys_clk_in);
   endtask
   task automatic wirq(output int t);
      int n;
      n = 0;
      @(negedge sys_clk_in);
      while (timer_match_irq_out !== 1'b1 && n < 3000) begin
         @(negedge sys_clk_in);
         n++;
      end
      if (n >= 3000) fail_count++;
      t = ticks;
      @(posedge sys_clk_in);
   endtask
   // settings only move while stopped, as the block does not guard them
   task automatic cfg(input logic [2:0] m, input logic p, input logic [15:0] v,
                      input logic [1:0] s);
      @(posedge sys_clk_in);
      start_control_in <= `MMT_START_STOP;
      @(posedge sys_clk_in);
      mode_in <= m;
      edge_polarity_select_in <= p;
      source_clock_select_in <= sel[2:0];
      capture_edge_mode_in <= cem;
      trigger_stop_select_in <= tss;
      cmp_wr_lo_in <= 1'b1;
      cmp_wdata_in <= v[7:0];
      @(posedge sys_clk_in);
      cmp_wr_lo_in <= 1'b0;
      cmp_wr_hi_in <= 1'b1;
      cmp_wdata_in <= v[15:8];
      @(posedge sys_clk_in);
      cmp_wr_hi_in <= 1'b0;
      start_control_in <= s;
      @(posedge sys_clk_in);
   endtask
   // edge timing of pulse captures drifts by one tick, so those notes carry slack
   always @(posedge sys_clk_in) begin
      if (timer_match_irq_out === 1'b1) begin
         nt = (notes.size() > 0) ? notes.pop_front() : 17'h1FFFF;
         obs = (mode_in == `MMT_MODE_PULSE) ? {capture_hi_out, capture_lo_out} : counter_out;
         if (nt[16] && (obs - nt[15:0] + 16'h1) <= 16'h2) obs = nt[15:0];
         check(obs, nt[15:0]);
      end
   end
   initial begin
      cyc(2);
      srst_in <= 1'b0;
      look(0);
      check({capture_hi_out, capture_lo_out}, `MMT_CAP_RST);
      check({counter_out, compare_armed_out, timer_match_irq_out}, 18'h2);
      cyc(1);
      start_control_in <= 2'h2;
      look(3);
      check({running_out, waiting_out}, 2'b00);
      sel = $random(seed) & 1;
      c = 16'h2 + ($random(seed) & 3);
      cfg(`MMT_MODE_TIMER, 1'b0, c, `MMT_START_CMD);
      repeat (2) notes.push_back({1'b0, `MMT_CNT_RST});
      wirq(t0);
      soft_capture_set_in <= 1'b1;
      cyc(1);
      soft_capture_set_in <= 1'b0;
      wirq(t1);
      check(20'(t1 - t0), 20'(c * (16 << (2 * sel))));
      sel = 0;
      cfg(`MMT_MODE_EXTTRIG, 1'b0, 16'h2, `MMT_START_EXT);
      repeat (2) notes.push_back({1'b0, `MMT_CNT_RST});
      repeat (2) begin
         i_mmt_pin_src.hold(1'b1, 24);
         wirq(t0);
         look(0);
         check({waiting_out, counter_out}, {1'b1, `MMT_CNT_RST});
         cyc(1);
         i_mmt_pin_src.hold(1'b0, 24);
      end
      tss = 1'b1;
      cfg(`MMT_MODE_EXTTRIG, 1'b0, 16'hFFFF, `MMT_START_EXT);
      i_mmt_pin_src.pulse(24, 100);
      i_mmt_pin_src.hold(1'b1, 24);
      look(0);
      c = counter_out;
      look(30);
      check({running_out, counter_out != 16'h0, counter_out}, {2'b01, c});
      tss = 1'b0;
      cfg(`MMT_MODE_EVENT, 1'b1, 16'h3, `MMT_START_CMD);
      notes.push_back({1'b0, `MMT_CNT_RST});
      i_mmt_pin_src.pulse(24, 24);
      i_mmt_pin_src.spike(5);
      i_mmt_pin_src.pulse(30, 30);
      look(0);
      check(counter_out, 16'h2);
      cyc(1);
      i_mmt_pin_src.pulse(24, 24);
      for (int p = 0; p < 2; p++) begin
         cfg(`MMT_MODE_WINDOW, p[0], 16'hFFFF, `MMT_START_CMD);
         i_mmt_pin_src.hold(p[0], 200);
         look(0);
         check(counter_out, 16'h0);
         cyc(1);
         i_mmt_pin_src.hold(!p[0], 200);
         look(0);
         check(counter_out > 16'h8, 1'b1);
      end
      for (int d = 0; d < 2; d++) begin
         cem = !d[0];
         cfg(`MMT_MODE_PULSE, 1'b0, 16'hFFFF, `MMT_START_EXT);
         notes.push_back({1'b1, 16'hA});
         if (d == 1) notes.push_back({1'b1, 16'h14});
         // the closing short pulse is captured once more
         notes.push_back({1'b1, 16'h3});
         i_mmt_pin_src.hold(1'b1, 160);
         i_mmt_pin_src.hold(1'b0, 160);
         look(0);
         check({waiting_out, running_out, counter_out == 16'h0}, {!d[0], d[0], !d[0]});
         cyc(1);
         i_mmt_pin_src.hold(1'b1, 40);
         i_mmt_pin_src.hold(1'b0, 24);
      end
      look(20);
      check(20'(notes.size()), 20'h0);
      tally_and_finish();
   end
   // the whole sequence needs well under 10000 cycles
   initial begin
      #100000;
      fail_count++;
      tally_and_finish();
   end
endmodule
